// [design/power_mode_defines.vh]
// Shared constants for the power mode state controller
`ifndef POWER_MODE_DEFINES_VH
`define POWER_MODE_DEFINES_VH

// Wake window after entering active mode, in microseconds
`define WAKE_WINDOW_US        9000
// Clock period in picoseconds (250 MHz)
`define REF_CLK_PERIOD_PS     4000
// Wake window in cycles; scaled in ns first so the product stays inside 32 bits
`define WAKE_WINDOW_CYCLES    ((`WAKE_WINDOW_US * 1000) / (`REF_CLK_PERIOD_PS / 1000))
// Wake filter settle time in nanoseconds and cycles
`define WAKE_FILTER_NS        1000
`define WAKE_FILTER_CYCLES    ((`WAKE_FILTER_NS * 1000) / `REF_CLK_PERIOD_PS)
// Sync boost default target in volts, carried as a code
`define SYNC_TARGET_12V       1'b0

`endif

// [design/level_sync.v]
// Two flip-flop synchroniser for a single asynchronous level
`timescale 1ns/10ps
module level_sync #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire ref_clk,
    input  wire rst_b,
    input  wire async_in,
    output reg  sync_out
);
    reg stage_one;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= RESET_VALUE;
            sync_out  <= RESET_VALUE;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

// [design/wake_filter.v]
// Digital glitch filter for the synchronised wake level
`timescale 1ns/10ps
`include "power_mode_defines.vh"
module wake_filter #(
    parameter FILTER_CYCLES = `WAKE_FILTER_CYCLES,
    parameter CNT_W         = 10
) (
    input  wire ref_clk,
    input  wire rst_b,
    input  wire raw_level,
    output reg  filtered_level
);
    reg [CNT_W-1:0] stable_count;

    // Output follows the input only after it stays different for the full time
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stable_count   <= {CNT_W{1'b0}};
            filtered_level <= 1'b0;
        end else if (raw_level == filtered_level) begin
            stable_count <= {CNT_W{1'b0}};
        end else if (stable_count >= FILTER_CYCLES[CNT_W-1:0] - 1'b1) begin
            stable_count   <= {CNT_W{1'b0}};
            filtered_level <= raw_level;
        end else begin
            stable_count <= stable_count + 1'b1;
        end
    end
endmodule

// [design/power_mode_state_controller.v]
// Power mode state machine with regulator sequencing and reserve control
`timescale 1ns/10ps
`include "power_mode_defines.vh"
module power_mode_state_controller #(
    parameter WAKE_WINDOW_CYCLES = `WAKE_WINDOW_CYCLES,
    parameter WAKE_FILTER_CYCLES = `WAKE_FILTER_CYCLES,
    parameter WINDOW_W           = 22
) (
    input  wire ref_clk,
    input  wire rst_b,
    input  wire wake_level,
    input  wire input_supply_good,
    input  wire input_supply_above_min,
    input  wire battery_good,
    input  wire sync_boost_good,
    input  wire sensor_buck_ramped,
    input  wire logic_supply_good,
    input  wire internal_por,
    input  wire cmd_sleep,
    input  wire cmd_switch_off,
    input  wire cmd_sensor_buck_off,
    input  wire cmd_switchers_off,
    input  wire cmd_charge_on,
    input  wire cmd_charge_off,
    input  wire cmd_discharge_on,
    input  wire cmd_discharge_off,
    output reg  internal_analog_regulator_en,
    output reg  internal_logic_regulator_en,
    output reg  reserve_boost_converter_en,
    output reg  sync_boost_converter_en,
    output reg  sync_boost_target_sel,
    output reg  sensor_buck_regulator_en,
    output reg  logic_supply_en,
    output reg  system_reset_b,
    output reg  charge_source_en,
    output reg  discharge_source_en,
    output reg  crossover_switch_en,
    output reg  crossover_active_output,
    output reg  functions_en,
    output reg  [7:0] power_state
);

    ////////////////////////////////////////////////////////////////////////////
    // States, one-hot
    localparam [7:0] ST_POWER_OFF = 8'h01;
    localparam [7:0] ST_WAKE_MON  = 8'h02;
    localparam [7:0] ST_AWAKE     = 8'h04;
    localparam [7:0] ST_STARTUP   = 8'h08;
    localparam [7:0] ST_RUN       = 8'h10;
    localparam [7:0] ST_SHUTDOWN  = 8'h20;
    localparam [7:0] ST_RESERVE   = 8'h40;
    localparam [7:0] ST_BLANKING  = 8'h80;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    wire wake_sync;
    wire vin_good_sync;
    wire vin_min_sync;
    wire batt_good_sync;
    wire sync_good_sync;
    wire buck_ramped_sync;
    wire logic_good_sync;
    wire por_sync;
    wire wake_filt;

    // Every analog indication crosses two flops first
    level_sync u_sync_wake   (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(wake_level),
                              .sync_out(wake_sync));
    level_sync u_sync_vgood  (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(input_supply_good),
                              .sync_out(vin_good_sync));
    level_sync u_sync_vmin   (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(input_supply_above_min),
                              .sync_out(vin_min_sync));
    level_sync u_sync_batt   (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(battery_good),
                              .sync_out(batt_good_sync));
    level_sync u_sync_sboost (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(sync_boost_good),
                              .sync_out(sync_good_sync));
    level_sync u_sync_buck   (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(sensor_buck_ramped),
                              .sync_out(buck_ramped_sync));
    level_sync u_sync_logic  (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(logic_supply_good),
                              .sync_out(logic_good_sync));
    level_sync u_sync_por    (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(internal_por),
                              .sync_out(por_sync));

    // Glitch filter on the wake level
    wake_filter #(
        .FILTER_CYCLES (WAKE_FILTER_CYCLES)
    ) u_wake_filter (
        .ref_clk        (ref_clk),
        .rst_b          (rst_b),
        .raw_level      (wake_sync),
        .filtered_level (wake_filt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and bookkeeping registers
    reg  [7:0]          state;
    reg  [7:0]          next_state;
    reg  [WINDOW_W-1:0] window_count;
    reg                 window_open;
    reg                 wake_timed_out;
    reg                 sleep_confirmed;
    reg                 charge_req;
    reg                 discharge_req;
    reg                 buck_on;
    reg                 logic_on;
    reg                 reset_released;

    wire in_active  = (state == ST_STARTUP) || (state == ST_RUN);
    wire in_sleep   = (state == ST_WAKE_MON) || (state == ST_AWAKE);
    wire in_passive = (state == ST_SHUTDOWN) || (state == ST_RESERVE) || (state == ST_BLANKING);

    // Switcher-off is refused while wake is high or the wake window is still open
    wire switchers_off_ok = cmd_switchers_off && !wake_filt && wake_timed_out;
    // Sleep command refused while wake is high
    wire sleep_ok = cmd_sleep && !wake_filt && !window_open;

    ////////////////////////////////////////////////////////////////////////////
    // Next state logic
    always @* begin
        next_state = state;
        case (state)
            ST_POWER_OFF: begin
                if (wake_filt)
                    next_state = ST_WAKE_MON;
            end
            ST_WAKE_MON: begin
                if (!wake_filt)
                    next_state = ST_POWER_OFF;
                else
                    next_state = ST_AWAKE;
            end
            ST_AWAKE: begin
                if (!wake_filt)
                    next_state = ST_POWER_OFF;
                else if (vin_min_sync)
                    next_state = ST_STARTUP;
            end
            ST_STARTUP, ST_RUN: begin
                if (window_open && !wake_filt)
                    next_state = ST_AWAKE;
                else if (!vin_good_sync && state == ST_RUN)
                    next_state = ST_RESERVE;
                else if (!vin_good_sync)
                    next_state = ST_BLANKING;
                else if (sleep_confirmed || cmd_switch_off)
                    next_state = ST_SHUTDOWN;
                else if (state == ST_STARTUP && reset_released)
                    next_state = ST_RUN;
            end
            ST_BLANKING: begin
                // Input supply recovered before run; no battery loss committed
                if (vin_good_sync)
                    next_state = ST_STARTUP;
                else if (!batt_good_sync)
                    next_state = ST_RESERVE;
            end
            ST_SHUTDOWN: begin
                if (cmd_sensor_buck_off || switchers_off_ok)
                    next_state = ST_POWER_OFF;
            end
            ST_RESERVE: begin
                // Only the internal power-on reset leaves this state
                next_state = ST_RESERVE;
            end
            default: next_state = ST_POWER_OFF;
        endcase
        if (por_sync)
            next_state = ST_POWER_OFF;
    end

    // State register
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            state <= ST_POWER_OFF;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake window, sleep confirmation and sequencing flags
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            window_count    <= {WINDOW_W{1'b0}};
            window_open     <= 1'b0;
            wake_timed_out  <= 1'b0;
            sleep_confirmed <= 1'b0;
        end else begin
            // Window restarts on every entry into active mode
            if (!in_active && (next_state == ST_STARTUP)) begin
                window_count <= {WINDOW_W{1'b0}};
                window_open  <= 1'b1;
            end else if (window_open) begin
                if (window_count >= WAKE_WINDOW_CYCLES[WINDOW_W-1:0] - 1'b1)
                    window_open <= 1'b0;
                window_count <= window_count + 1'b1;
            end
            // Timeout only matters once wake has dropped after the window
            wake_timed_out <= !window_open && !wake_filt && (in_active || in_passive);
            // Sleep confirmation latched only while wake is low; lost if wake returns
            if (!in_active || wake_filt)
                sleep_confirmed <= 1'b0;
            else if (sleep_ok)
                sleep_confirmed <= 1'b1;
        end
    end

    // Regulator sequencing inside active and passive modes
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            buck_on        <= 1'b0;
            logic_on       <= 1'b0;
            reset_released <= 1'b0;
        end else if (!(in_active || in_passive)) begin
            buck_on        <= 1'b0;
            logic_on       <= 1'b0;
            reset_released <= 1'b0;
        end else begin
            if (sync_good_sync)
                buck_on <= 1'b1;
            if (buck_on && buck_ramped_sync)
                logic_on <= 1'b1;
            if (logic_on && logic_good_sync)
                reset_released <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charge and discharge requests from the microcontroller
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            charge_req    <= 1'b0;
            discharge_req <= 1'b0;
        end else begin
            // Charge commands act only in active mode after reset release
            if (!in_active)
                charge_req <= 1'b0;
            else if (reset_released && cmd_charge_on)
                charge_req <= 1'b1;
            else if (cmd_charge_off)
                charge_req <= 1'b0;
            // Discharge is mutually exclusive with charge; last command wins
            if (in_sleep || state == ST_POWER_OFF)
                discharge_req <= 1'b0;
            else if (cmd_discharge_on)
                discharge_req <= 1'b1;
            else if (cmd_discharge_off || (in_active && cmd_charge_on))
                discharge_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs per substate
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            internal_analog_regulator_en <= 1'b0;
            internal_logic_regulator_en  <= 1'b0;
            reserve_boost_converter_en   <= 1'b0;
            sync_boost_converter_en      <= 1'b0;
            sync_boost_target_sel        <= `SYNC_TARGET_12V;
            sensor_buck_regulator_en     <= 1'b0;
            logic_supply_en              <= 1'b0;
            system_reset_b               <= 1'b0;
            charge_source_en             <= 1'b0;
            discharge_source_en          <= 1'b0;
            crossover_switch_en          <= 1'b0;
            crossover_active_output      <= 1'b0;
            functions_en                 <= 1'b0;
            power_state                  <= ST_POWER_OFF;
        end else begin
            power_state <= state;
            // Everything off in power-off; internal rails from awake on, still off in wake monitor
            internal_analog_regulator_en <= (state != ST_POWER_OFF) && (state != ST_WAKE_MON);
            internal_logic_regulator_en  <= (state != ST_POWER_OFF) && (state != ST_WAKE_MON);
            // Reserve boost runs in active and blanking, off in shutdown and reserve
            reserve_boost_converter_en   <= in_active || (state == ST_BLANKING);
            sync_boost_converter_en      <= in_active || in_passive;
            sync_boost_target_sel        <= `SYNC_TARGET_12V;
            // Supplies gated off outside active and passive
            sensor_buck_regulator_en     <= buck_on && (in_active || in_passive);
            logic_supply_en              <= logic_on && (in_active || in_passive);
            system_reset_b               <= reset_released && (in_active || in_passive);
            charge_source_en             <= charge_req && in_active && !discharge_req;
            discharge_source_en          <= discharge_req && (in_active || state == ST_SHUTDOWN);
            crossover_switch_en          <= in_passive;
            crossover_active_output      <= (state == ST_SHUTDOWN) || (state == ST_RESERVE);
            functions_en                 <= in_active || in_passive;
        end
    end

endmodule

// [dv/power_mode_monitor.sv]
// Port-level checker for the power mode state controller
`timescale 1ns/10ps
module power_mode_monitor (
    input wire       ref_clk,
    input wire       rst_b,
    input wire       internal_por,
    input wire       sync_boost_good,
    input wire       sensor_buck_ramped,
    input wire       logic_supply_good,
    input wire       internal_analog_regulator_en,
    input wire       internal_logic_regulator_en,
    input wire       reserve_boost_converter_en,
    input wire       sync_boost_converter_en,
    input wire       sync_boost_target_sel,
    input wire       sensor_buck_regulator_en,
    input wire       logic_supply_en,
    input wire       system_reset_b,
    input wire       charge_source_en,
    input wire       discharge_source_en,
    input wire       crossover_switch_en,
    input wire       crossover_active_output,
    input wire       functions_en,
    input wire [7:0] power_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // State held two edges, so the one-cycle output lag never trips a check
    logic [7:0] prev1;
    logic [7:0] prev2;
    wire        steady = (prev1 == power_state) && (prev2 == power_state);
    wire        any_sup = |{internal_analog_regulator_en, internal_logic_regulator_en, reserve_boost_converter_en,
                            sync_boost_converter_en, sensor_buck_regulator_en, logic_supply_en, system_reset_b};
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev1 <= 8'h01;
            prev2 <= 8'h01;
        end else begin
            prev1 <= power_state;
            prev2 <= prev1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_off_quiet; steady && power_state == 8'h01 |-> !any_sup; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("supply on in power-off");
    property p_sleep_funcs; steady && (power_state & 8'h06) != 8'h00 |-> !(functions_en | logic_supply_en); endproperty
    a_sleep_funcs: assert property (p_sleep_funcs) else $error("function on in sleep");
    property p_charge; steady && (power_state & 8'h18) == 8'h00 |-> !charge_source_en; endproperty
    a_charge: assert property (p_charge) else $error("charge source on in wrong substate");
    property p_discharge; steady && (power_state & 8'h38) == 8'h00 |-> !discharge_source_en; endproperty
    a_discharge: assert property (p_discharge) else $error("discharge source on in wrong substate");
    property p_switch; steady && power_state[7:5] == 3'h0 |-> !crossover_switch_en; endproperty
    a_switch: assert property (p_switch) else $error("crossover switch outside passive");
    property p_indicator; steady && (power_state & 8'h60) == 8'h00 |-> !crossover_active_output; endproperty
    a_indicator: assert property (p_indicator) else $error("crossover indicator in wrong substate");
    property p_reset_rel; $rose(system_reset_b) |-> $past(logic_supply_good, 2); endproperty
    a_reset_rel: assert property (p_reset_rel) else $error("reset released before logic supply good");
    property p_logic_order; $rose(logic_supply_en) |-> sensor_buck_regulator_en && $past(sensor_buck_ramped, 2);
    endproperty
    a_logic_order: assert property (p_logic_order) else $error("logic supply before buck ramp");
    property p_boost_start; $rose(power_state[3]) |-> ##[0:2] reserve_boost_converter_en && !sync_boost_target_sel;
    endproperty
    a_boost_start: assert property (p_boost_start) else $error("boost not started in startup");
    property p_reserve_exit; $fell(power_state[6]) |-> $past(internal_por, 2); endproperty
    a_reserve_exit: assert property (p_reserve_exit) else $error("reserve left without power-on reset");
    c_run: cover property (power_state == 8'h10);
    c_shutdown: cover property (power_state == 8'h20);
    c_blank: cover property (power_state == 8'h80);
endmodule
bind power_mode_state_controller power_mode_monitor u_mon (.ref_clk, .rst_b, .internal_por, .sync_boost_good,
    .sensor_buck_ramped, .logic_supply_good, .internal_analog_regulator_en, .internal_logic_regulator_en,
    .reserve_boost_converter_en, .sync_boost_converter_en, .sync_boost_target_sel, .sensor_buck_regulator_en,
    .logic_supply_en, .system_reset_b, .charge_source_en, .discharge_source_en, .crossover_switch_en,
    .crossover_active_output, .functions_en, .power_state);

// [dv/supply_partner.sv]
// Regulator-side model answering enables with good flags after a ramp
`timescale 1ns/10ps
module supply_partner (
    input wire   ref_clk,
    input wire   slow,
    input wire   sync_boost_converter_en,
    input wire   sensor_buck_regulator_en,
    input wire   logic_supply_en,
    output logic sync_boost_good,
    output logic sensor_buck_ramped,
    output logic logic_supply_good
);
    wire [2:0]  en = {logic_supply_en, sensor_buck_regulator_en, sync_boost_converter_en};
    logic [4:0] cnt [0:2] = '{5'h00, 5'h00, 5'h00};
    logic [2:0] good = 3'h0;
    assign {logic_supply_good, sensor_buck_ramped, sync_boost_good} = good;
    // Good rises after a ramp and drops at once when disabled; slow mode stretches the ramp
    always @(negedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] <= en[i] ? cnt[i] + {4'h0, cnt[i] != 5'h1f} : 5'h00;
            good[i] <= en[i] && (cnt[i] >= (slow ? 5'd20 : 5'd3));
        end
    end
endmodule

// [dv/tb_power_mode_state_controller.sv]
// Self-checking bench for the power mode state controller
`timescale 1ns/10ps
module tb_power_mode_state_controller;
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       wake_level = 1'b0;
    logic       input_supply_good = 1'b1;
    logic       input_supply_above_min = 1'b0;
    logic       battery_good = 1'b1;
    logic       internal_por = 1'b0;
    logic       slow = 1'b0;
    logic [7:0] cmds = 8'h00;
    int         bad_count = 0;
    int         comparisons = 0;
    wire        sync_boost_good, sensor_buck_ramped, logic_supply_good, sync_boost_target_sel;
    wire        internal_analog_regulator_en, internal_logic_regulator_en, reserve_boost_converter_en;
    wire        sync_boost_converter_en, sensor_buck_regulator_en, logic_supply_en, system_reset_b;
    wire        charge_source_en, discharge_source_en, crossover_switch_en, crossover_active_output, functions_en;
    wire [7:0]  power_state;
    power_mode_state_controller #(.WAKE_WINDOW_CYCLES(100), .WAKE_FILTER_CYCLES(4)) u_dut (
        .ref_clk, .rst_b, .wake_level, .input_supply_good, .input_supply_above_min, .battery_good,
        .sync_boost_good, .sensor_buck_ramped, .logic_supply_good, .internal_por,
        .cmd_sleep(cmds[0]), .cmd_switch_off(cmds[1]), .cmd_sensor_buck_off(cmds[2]), .cmd_switchers_off(cmds[3]),
        .cmd_charge_on(cmds[4]), .cmd_charge_off(cmds[5]), .cmd_discharge_on(cmds[6]), .cmd_discharge_off(cmds[7]),
        .internal_analog_regulator_en, .internal_logic_regulator_en, .reserve_boost_converter_en,
        .sync_boost_converter_en, .sync_boost_target_sel, .sensor_buck_regulator_en, .logic_supply_en,
        .system_reset_b, .charge_source_en, .discharge_source_en, .crossover_switch_en,
        .crossover_active_output, .functions_en, .power_state);
    supply_partner u_partner (.ref_clk, .slow, .sync_boost_converter_en, .sensor_buck_regulator_en,
        .logic_supply_en, .sync_boost_good, .sensor_buck_ramped, .logic_supply_good);
    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and timing helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bounded wait for any substate in the mask
    task automatic wait_in(input logic [7:0] mask);
        int n;
        n = 0;
        while ((power_state & mask) == 8'h00 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        chk("state_in_mask", {7'h0, |(power_state & mask)}, 8'h01);
    endtask
    // One-cycle command pulse, then a gap so pulses never merge
    task automatic cmd(input int k);
        cmds = 8'h01 << k;
        settle(1);
        cmds = 8'h00;
        settle(1);
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        {wake_level, input_supply_above_min, internal_por, slow} = 4'h0;
        {input_supply_good, battery_good} = 2'h3;
        settle(4);
        rst_b = 1'b1;
        settle(2);
    endtask
    task automatic power_up(input logic to_run);
        wake_level = 1'b1;
        wait_in(8'h04);
        settle(2);
        chk("sleep_regs", {internal_analog_regulator_en, internal_logic_regulator_en,
                           sync_boost_converter_en}, 8'h06);
        input_supply_above_min = 1'b1;
        wait_in(8'h08);
        settle(2);
        chk("boosts", {reserve_boost_converter_en, sync_boost_converter_en, sync_boost_target_sel}, 8'h06);
        if (to_run) begin
            wait_in(8'h10);
            settle(2);
            chk("run_out", {system_reset_b, sensor_buck_regulator_en, logic_supply_en, functions_en}, 8'h0f);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_off();
        chk("off_state", power_state, 8'h01);
        cmd(4);
        settle(3);
        chk("charge_in_off", {7'h0, charge_source_en}, 8'h00);
        wake_level = 1'b1;
        settle(2);
        wake_level = 1'b0;
        settle(20);
        chk("glitch", power_state, 8'h01);
    endtask
    task automatic t_early();
        do_reset();
        power_up(1'b1);
        wake_level = 1'b0;
        wait_in(8'h06);
        settle(2);
        chk("sleep_buck", {7'h0, sensor_buck_regulator_en}, 8'h00);
    endtask
    // Window expiry, refusals, then shutdown and power-off by either command
    task automatic t_late(input logic use_sw);
        do_reset();
        slow = use_sw;
        power_up(1'b1);
        settle(120);
        cmd(0);
        cmd(3);
        settle(10);
        chk("wake_hi_refuse", power_state, 8'h10);
        cmd(4);
        settle(3);
        chk("charge_on", {7'h0, charge_source_en}, 8'h01);
        cmd(5);
        settle(3);
        chk("charge_off", {7'h0, charge_source_en}, 8'h00);
        wake_level = 1'b0;
        settle(20);
        chk("wake_lo_hold", power_state, 8'h10);
        // Sleep confirmation on one pass, switch-off command on the other
        cmd(use_sw ? 1 : 0);
        wait_in(8'h20);
        settle(2);
        chk("shutdown", {crossover_switch_en, crossover_active_output,
                         charge_source_en, reserve_boost_converter_en}, 8'h0c);
        cmd(6);
        settle(3);
        chk("discharge", {7'h0, discharge_source_en}, 8'h01);
        cmd(7);
        settle(3);
        chk("discharge_off", {7'h0, discharge_source_en}, 8'h00);
        cmd(use_sw ? 3 : 2);
        wait_in(8'h01);
        settle(2);
        chk("all_off", {functions_en, crossover_switch_en, system_reset_b,
                        internal_analog_regulator_en}, 8'h00);
    endtask
    task automatic t_vin();
        do_reset();
        power_up(1'b1);
        input_supply_good = 1'b0;
        wait_in(8'h40);
        settle(30);
        chk("reserve_hold", power_state, 8'h40);
        chk("reserve_out", {crossover_switch_en, crossover_active_output, charge_source_en}, 8'h06);
        internal_por = 1'b1;
        wait_in(8'h01);
    endtask
    // Input good lost mid-startup blanks, then battery loss goes to reserve
    task automatic t_blank();
        do_reset();
        slow = 1'b1;
        power_up(1'b0);
        input_supply_good = 1'b0;
        wait_in(8'h80);
        settle(2);
        chk("blanking", {crossover_switch_en, crossover_active_output}, 8'h02);
        battery_good = 1'b0;
        wait_in(8'h40);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Watchdog well past the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        do_reset();
        t_off();
        t_early();
        t_late(1'b0);
        t_late(1'b1);
        t_vin();
        t_blank();
        end_sim();
    end
endmodule
